/* File: shared/ncp_pkg.sv */
// constants, types and check-byte function shared by both ends of the link
`default_nettype none
package ncp_pkg;
  localparam int ADDR_W = 7;
  localparam logic [6:0] ADDR_STATUS = 7'h70;
  localparam logic [6:0] ADDR_STARTUP = 7'h73;
  localparam logic [6:0] ADDR_CHIP = 7'h74;
  localparam logic [6:0] ADDR_CRC = 7'h75;
  localparam int STAT_PROG_BIT = 0;
  localparam int STAT_ECC_BIT = 1;
  localparam int STAT_CNT_LSB = 2;
  localparam int CNT_W = 6;
  localparam int FN_SELECT_BIT = 3;
  localparam logic [7:0] PRESET_STARTUP = 8'h00;
  localparam logic [7:0] PRESET_CHIP = 8'h08;
  localparam logic [7:0] CRC_POLY = 8'h2f;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [7:0] CRC_XOR = 8'hff;
  localparam int CLK_MHZ = 125;
  localparam int BURN_TIME_US = 10;
  localparam int BURN_CYCLES = BURN_TIME_US * CLK_MHZ;
  localparam int SYSRST_TIME_US = 1;
  localparam int SYSRST_CYCLES = SYSRST_TIME_US * CLK_MHZ;
  localparam int PROG_LIMIT = 200;
  localparam logic [1:0] HREG_CTRL = 2'h0;
  localparam logic [1:0] HREG_STARTUP = 2'h1;
  localparam logic [1:0] HREG_CHIP = 2'h2;
  localparam logic [1:0] HREG_RESULT = 2'h3;
  localparam logic [1:0] HERR_NONE = 2'h0;
  localparam logic [1:0] HERR_REFUSED = 2'h1;
  localparam logic [1:0] HERR_LIMIT = 2'h2;

  typedef enum logic [1:0] {
    DST_RUN = 2'b00,
    DST_BURN = 2'b01,
    DST_RESET = 2'b10,
    DST_HALT = 2'b11
  } ncp_dev_state_t;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_RDSTAT = 3'b001,
    HST_CHECK = 3'b010,
    HST_W73 = 3'b011,
    HST_W74 = 3'b100,
    HST_W75 = 3'b101,
    HST_WAITRST = 3'b110,
    HST_WAITREL = 3'b111
  } ncp_host_state_t;

  // check byte over the two staged bytes
  function automatic logic [7:0] ncp_check(input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [7:0] crc;
    logic [15:0] data;
    crc = CRC_INIT;
    data = {lo, hi};
    for (int i = 0; i < 16; i++)
    begin
      if (crc[7] ^ data[15 - i])
        crc = {crc[6:0], 1'b0} ^ CRC_POLY;
      else
        crc = {crc[6:0], 1'b0};
    end
    return crc ^ CRC_XOR;
  endfunction
endpackage
`default_nettype wire

/* File: shared/ncp_link_if.sv */
// register link between host controller and configuration device
`timescale 1ns/100ps
`default_nettype none
interface ncp_link_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic forced_normal;
  logic sys_reset;

  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata,
    output forced_normal,
    output sys_reset
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata,
    input forced_normal,
    input sys_reset
  );
endinterface
`default_nettype wire

/* File: hw/ncp_nv_device.sv */
// non-volatile configuration cells with check-byte confirmed programming
`timescale 1ns/100ps
`default_nettype none
module ncp_nv_device #(
  parameter int BURN_CNT = ncp_pkg::BURN_CYCLES,
  parameter int SYSRST_CNT = ncp_pkg::SYSRST_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ncp_link_if.dev link,
  input wire logic i_factory_restore,
  input wire logic i_cell_fault_single,
  input wire logic i_cell_fault_multi,
  output logic [7:0] o_cfg_startup,
  output logic [7:0] o_cfg_chip,
  output logic o_forced_normal,
  output logic o_busy,
  output logic o_sys_reset
);
  import ncp_pkg::*;

  localparam int TW = 12;

  // a preset image must select forced normal, otherwise a restore
  // could not bring the device back to where programming is allowed
  if (!PRESET_CHIP[FN_SELECT_BIT])
    $error("preset image must select forced normal");
  // the status byte leaves exactly six bits for the counter
  if (CNT_W != 6)
    $error("counter width must fill status bits 7:2");
  if (BURN_CNT < 1 || BURN_CNT >= 2 ** TW)
    $error("burn count out of range");
  if (SYSRST_CNT < 1 || SYSRST_CNT >= 2 ** TW)
    $error("system reset count out of range");

  // the cell copies stand for the non-volatile array: they survive a
  // system reset but not i_rst_n, which acts as power-on and reloads
  // the presets
  typedef struct packed {
    ncp_dev_state_t state;
    logic [7:0] stage_startup;
    logic [7:0] stage_chip;
    logic [7:0] cell_startup;
    logic [7:0] cell_chip;
    logic [7:0] check_byte;
    logic programmable_flag;
    logic single_bit_corrected_flag;
    logic multi_fault;
    logic [5:0] program_count;
    logic forced_normal;
    logic busy;
    logic sys_reset;
    logic [TW-1:0] timer;
    logic [7:0] rdata;
  } ncp_dev_t;

  localparam logic [TW-1:0] BURN_LAST = TW'(BURN_CNT - 1);
  localparam logic [TW-1:0] SYSRST_LAST = TW'(SYSRST_CNT - 1);
  localparam logic [5:0] CNT_MAX = 6'h3f;

  // saturating step: the counter is informational and never wraps
  function automatic logic [5:0] count_step(input logic [5:0] c);
    if (c == CNT_MAX)
      return c;
    else
      return c + 6'h01;
  endfunction

  ncp_dev_t s_q;
  ncp_dev_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    // fault flags are sticky; nothing here clears them
    if (i_cell_fault_single)
      s_d.single_bit_corrected_flag = 1'b1;
    if (i_cell_fault_multi)
      s_d.multi_fault = 1'b1;
    // status stays readable in every state
    if (link.rd && link.addr == ADDR_STATUS)
      s_d.rdata = {s_q.program_count, s_q.single_bit_corrected_flag,
                   s_q.programmable_flag};
    case (s_q.state)
      DST_RUN:
      begin
        if (link.rd)
        begin
          case (link.addr)
            ADDR_STARTUP: s_d.rdata = s_q.stage_startup;
            ADDR_CHIP: s_d.rdata = s_q.stage_chip;
            ADDR_CRC: s_d.rdata = s_q.check_byte;
            default: ;
          endcase
        end
        if (i_factory_restore)
        begin
          // restore outranks any bus write in the same cycle
          s_d.cell_startup = PRESET_STARTUP;
          s_d.cell_chip = PRESET_CHIP;
          s_d.programmable_flag = 1'b1;
          s_d.program_count = count_step(s_q.program_count);
          s_d.state = DST_RESET;
          s_d.sys_reset = 1'b1;
          s_d.timer = SYSRST_LAST;
        end
        else if (link.wr)
        begin
          case (link.addr)
            ADDR_STARTUP:
              if (s_q.programmable_flag)
                s_d.stage_startup = link.wdata;
            ADDR_CHIP:
              if (s_q.programmable_flag)
                s_d.stage_chip = link.wdata;
            ADDR_CRC:
            begin
              s_d.check_byte = link.wdata;
              // a saturated counter does not gate this
              if (s_q.forced_normal && s_q.programmable_flag &&
                  link.wdata == ncp_check(s_q.stage_startup,
                                          s_q.stage_chip))
              begin
                s_d.state = DST_BURN;
                s_d.busy = 1'b1;
                s_d.timer = BURN_LAST;
              end
              // mismatch: staged bytes kept, cells untouched
            end
            default: ;
          endcase
        end
      end
      DST_BURN:
      begin
        // config reads give zero and writes drop while burning
        // the cells keep the old image until the timer expires, then both take the staged bytes together
        if (link.rd && link.addr inside {ADDR_STARTUP, ADDR_CHIP, ADDR_CRC})
          s_d.rdata = 8'h00;
        if (s_q.timer != '0)
          s_d.timer = s_q.timer - TW'(1);
        else
        begin
          s_d.cell_startup = s_q.stage_startup;
          s_d.cell_chip = s_q.stage_chip;
          s_d.programmable_flag = 1'b0;
          s_d.program_count = count_step(s_q.program_count);
          s_d.busy = 1'b0;
          s_d.sys_reset = 1'b1;
          s_d.timer = SYSRST_LAST;
          if (s_q.multi_fault || i_cell_fault_multi)
            s_d.state = DST_HALT;
          else
            s_d.state = DST_RESET;
        end
      end
      DST_RESET:
      begin
        if (s_q.timer != '0)
          s_d.timer = s_q.timer - TW'(1);
        else
        begin
          s_d.sys_reset = 1'b0;
          s_d.state = DST_RUN;
          // staged copies follow the cells again after the restart
          s_d.stage_startup = s_q.cell_startup;
          s_d.stage_chip = s_q.cell_chip;
          // preset cells carry the forced normal bit set
          s_d.forced_normal = s_q.cell_chip[FN_SELECT_BIT];
        end
      end
      DST_HALT:
      begin
        // a multi-fault device never restarts; only i_rst_n leaves here
        s_d.sys_reset = 1'b1;
      end
      default:
        s_d.state = DST_RUN;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
      s_q.state <= DST_RUN;
      s_q.stage_startup <= PRESET_STARTUP;
      s_q.stage_chip <= PRESET_CHIP;
      s_q.cell_startup <= PRESET_STARTUP;
      s_q.cell_chip <= PRESET_CHIP;
      s_q.programmable_flag <= 1'b1;
      s_q.forced_normal <= PRESET_CHIP[FN_SELECT_BIT];
    end
    else
      s_q <= s_d;
  end

  assign link.rdata = s_q.rdata;
  assign link.forced_normal = s_q.forced_normal;
  assign link.sys_reset = s_q.sys_reset;
  assign o_cfg_startup = s_q.cell_startup;
  assign o_cfg_chip = s_q.cell_chip;
  assign o_forced_normal = s_q.forced_normal;
  assign o_busy = s_q.busy;
  assign o_sys_reset = s_q.sys_reset;
endmodule
`default_nettype wire

/* File: hw/ncp_host_ctrl.sv */
// host-side controller that stages, confirms and tracks a programming cycle
`timescale 1ns/100ps
`default_nettype none
module ncp_host_ctrl #(
  parameter int LIMIT = ncp_pkg::PROG_LIMIT
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ncp_link_if.host link,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata
);
  import ncp_pkg::*;

  if (LIMIT < 1 || LIMIT > 255)
    $error("programming limit out of range");

  typedef struct packed {
    ncp_host_state_t state;
    logic [7:0] want_startup;
    logic [7:0] want_chip;
    logic [7:0] dev_status;
    logic [7:0] issued;
    logic [1:0] err;
    logic done;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
  } ncp_host_t;

  localparam logic [7:0] LIMIT_B = 8'(LIMIT);

  ncp_host_t s_q;
  ncp_host_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    s_d.rdata = 8'h00;
    if (i_rd)
    begin
      case (i_addr)
        HREG_CTRL:
          s_d.rdata = {4'h0, s_q.err, s_q.done, s_q.state != HST_IDLE};
        HREG_STARTUP: s_d.rdata = s_q.want_startup;
        HREG_CHIP: s_d.rdata = s_q.want_chip;
        HREG_RESULT: s_d.rdata = s_q.dev_status;
        default: ;
      endcase
    end
    if (i_wr && s_q.state == HST_IDLE)
    begin
      case (i_addr)
        HREG_STARTUP: s_d.want_startup = i_wdata;
        HREG_CHIP: s_d.want_chip = i_wdata;
        HREG_CTRL:
          if (i_wdata[0])
          begin
            s_d.done = 1'b0;
            s_d.err = HERR_NONE;
            if (s_q.issued >= LIMIT_B)
            begin
              s_d.err = HERR_LIMIT;
              s_d.done = 1'b1;
            end
            else
            begin
              s_d.state = HST_RDSTAT;
              s_d.rd = 1'b1;
              s_d.addr = ADDR_STATUS;
            end
          end
        default: ;
      endcase
    end
    case (s_q.state)
      HST_IDLE: ;
      HST_RDSTAT:
        s_d.state = HST_CHECK;
      HST_CHECK:
      begin
        s_d.dev_status = link.rdata;
        if (!link.forced_normal || !link.rdata[STAT_PROG_BIT])
        begin
          s_d.err = HERR_REFUSED;
          s_d.done = 1'b1;
          s_d.state = HST_IDLE;
        end
        else
        begin
          s_d.wr = 1'b1;
          s_d.addr = ADDR_STARTUP;
          s_d.wdata = s_q.want_startup;
          s_d.state = HST_W73;
        end
      end
      HST_W73:
      begin
        s_d.wr = 1'b1;
        s_d.addr = ADDR_CHIP;
        s_d.wdata = s_q.want_chip;
        s_d.state = HST_W74;
      end
      HST_W74:
      begin
        s_d.wr = 1'b1;
        s_d.addr = ADDR_CRC;
        s_d.wdata = ncp_check(s_q.want_startup, s_q.want_chip);
        s_d.state = HST_W75;
      end
      HST_W75:
      begin
        s_d.issued = s_q.issued + 8'h01;
        s_d.state = HST_WAITRST;
      end
      // no reads are issued until the device has reset
      HST_WAITRST:
        if (link.sys_reset)
          s_d.state = HST_WAITREL;
      HST_WAITREL:
        if (!link.sys_reset)
        begin
          s_d.done = 1'b1;
          s_d.state = HST_IDLE;
        end
      default:
        s_d.state = HST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
      s_q.state <= HST_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign link.addr = s_q.addr;
  assign link.wdata = s_q.wdata;
  assign link.wr = s_q.wr;
  assign link.rd = s_q.rd;
  assign o_rdata = s_q.rdata;
endmodule
`default_nettype wire

/* File: verification/ncp_link_checker.sv */
// protocol checker for the link between host controller and nv device
`timescale 1ns/100ps
`default_nettype none
module ncp_link_checker #(
  parameter int BURN_CNT = ncp_pkg::BURN_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic forced_normal,
  input wire logic sys_reset
);
  import ncp_pkg::*;

  // slack on top of the burn time for the confirm-to-reset latency
  localparam int BURN_MAX = BURN_CNT + 4;

  // the delay range below only suits shortened burn times
  if (BURN_MAX > 1000)
    $error("burn count too long for the checker");
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  AST_ONE_STROBE: assert property (
    !(wr && rd)) else $error("write and read strobe together");
  AST_RDATA_AFTER_RD: assert property (
    rdata != 8'h00 |-> $past(rd)) else $error("read data outside slot");
  AST_SYSRST_HOLD: assert property (
    $rose(sys_reset) |-> sys_reset[*3]) else $error("system reset short");
  AST_FN_AT_RESET_END: assert property (
    $changed(forced_normal) |-> $fell(sys_reset))
    else $error("forced normal moved outside reset end");
  AST_NO_WR_IN_SYSRST: assert property (
    sys_reset |-> !wr) else $error("write during system reset");
  AST_CONFIRM_ORDER: assert property (
    wr && addr == ADDR_CRC |-> $past(wr) && $past(addr) == ADDR_CHIP
      && $past(wr, 2) && $past(addr, 2) == ADDR_STARTUP)
    else $error("confirm not after both staged bytes");
  AST_STATUS_FIRST: assert property (
    wr && addr == ADDR_STARTUP |-> $past(rd, 2)
      && $past(addr, 2) == ADDR_STATUS)
    else $error("staging without status read");
  AST_FN_BEFORE_STAGE: assert property (
    wr && addr == ADDR_STARTUP |-> forced_normal)
    else $error("staging outside forced normal");
  AST_BURN_ENDS: assert property (
    wr && addr == ADDR_CRC |-> ##[1:BURN_MAX] $rose(sys_reset))
    else $error("no system reset after confirm");
endmodule
`default_nettype wire

/* File: verification/nv_config_crc_programmer_test.sv */
// self-checking bench: host controller and nv device joined by the link
`timescale 1ns/100ps
`default_nettype none
module nv_config_crc_programmer_test;
  import ncp_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [1:0] h_addr = 2'h0;
  logic [7:0] h_wdata = 8'h00;
  logic h_wr = 1'b0;
  logic h_rd = 1'b0;
  logic f_restore = 1'b0;
  logic f_single = 1'b0;
  logic f_multi = 1'b0;
  logic [7:0] h_rdata, cfg_lo, cfg_hi, rv, st_lo, st_hi;
  logic fn, busy, sys_rst;
  logic busy_seen = 1'b0;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  ncp_link_if link ();
  ncp_nv_device #(.BURN_CNT(4), .SYSRST_CNT(3)) ncp_nv_device_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link),
    .i_factory_restore(f_restore), .i_cell_fault_single(f_single),
    .i_cell_fault_multi(f_multi), .o_cfg_startup(cfg_lo),
    .o_cfg_chip(cfg_hi), .o_forced_normal(fn), .o_busy(busy),
    .o_sys_reset(sys_rst));
  ncp_host_ctrl #(.LIMIT(2)) ncp_host_ctrl_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link),
    .i_addr(h_addr), .i_wdata(h_wdata), .i_wr(h_wr), .i_rd(h_rd),
    .o_rdata(h_rdata));
  ncp_link_checker #(.BURN_CNT(4)) ncp_link_checker_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .forced_normal(link.forced_normal), .sys_reset(link.sys_reset));
  always #4 i_ref_clk = ~i_ref_clk;

  // byte-wise form, kept apart from the bit-serial one in the design
  function automatic logic [7:0] ref_crc(input logic [7:0] b0,
                                         input logic [7:0] b1);
    logic [7:0] crc;
    logic [7:0] d;
    crc = 8'hff;
    for (int i = 0; i < 2; i++)
    begin
      d = (i == 0 ? b0 : b1) ^ crc;
      for (int j = 0; j < 8; j++)
        d = d[7] ? ({d[6:0], 1'b0} ^ 8'h2f) : {d[6:0], 1'b0};
      crc = d;
    end
    return crc ^ 8'hff;
  endfunction

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic hwr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    h_addr <= a;
    h_wdata <= d;
    h_wr <= 1'b1;
    @(posedge i_ref_clk);
    h_wr <= 1'b0;
  endtask

  task automatic hrd(input logic [1:0] a);
    @(posedge i_ref_clk);
    h_addr <= a;
    h_rd <= 1'b1;
    @(posedge i_ref_clk);
    h_rd <= 1'b0;
    @(negedge i_ref_clk);
    rv = h_rdata;
  endtask

  task automatic start(input logic [7:0] lo, input logic [7:0] hi);
    st_lo = lo;
    st_hi = hi;
    hwr(HREG_STARTUP, lo);
    hwr(HREG_CHIP, hi);
    hwr(HREG_CTRL, 8'h01);
  endtask

  // polling is bounded so a stuck controller cannot hang the run
  task automatic wait_done();
    int n;
    n = 0;
    hrd(HREG_CTRL);
    while (rv[1] !== 1'b1 && n < 100)
    begin
      hrd(HREG_CTRL);
      n++;
    end
  endtask

  always @(posedge i_ref_clk)
  begin
    cycles <= cycles + 1;
    if (busy === 1'b1)
      busy_seen <= 1'b1;
    if (link.wr === 1'b1 && link.addr === ADDR_CRC)
      chk("check byte", link.wdata, ref_crc(st_lo, st_hi));
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end

  initial
  begin
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(negedge i_ref_clk);
    chk("cell lo", cfg_lo, PRESET_STARTUP);
    chk("cell hi", cfg_hi, PRESET_CHIP);
    chk("forced normal", {7'h00, fn}, 8'h01);
    start(8'h25, 8'h0c);
    hwr(HREG_STARTUP, 8'hff);
    wait_done();
    chk("ctrl ok", rv, 8'h02);
    chk("cell lo", cfg_lo, 8'h25);
    chk("cell hi", cfg_hi, 8'h0c);
    hrd(HREG_STARTUP);
    chk("wanted lo", rv, 8'h25);
    @(posedge i_ref_clk);
    f_single <= 1'b1;
    @(posedge i_ref_clk);
    f_single <= 1'b0;
    hwr(HREG_CTRL, 8'h01);
    wait_done();
    chk("ctrl refused", rv, 8'h06);
    hrd(HREG_RESULT);
    chk("status", rv, 8'h06);
    chk("cell lo kept", cfg_lo, 8'h25);
    @(posedge i_ref_clk);
    f_restore <= 1'b1;
    @(posedge i_ref_clk);
    f_restore <= 1'b0;
    repeat (20) @(posedge i_ref_clk);
    chk("restored hi", cfg_hi, PRESET_CHIP);
    chk("fn restored", {7'h00, fn}, 8'h01);
    start(8'h11, 8'h02);
    wait_done();
    chk("cell hi", cfg_hi, 8'h02);
    chk("fn off", {7'h00, fn}, 8'h00);
    hrd(HREG_RESULT);
    chk("status count 2", rv, 8'h0b);
    hwr(HREG_CTRL, 8'h01);
    wait_done();
    chk("ctrl limit", rv, 8'h0a);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    f_multi <= 1'b1;
    @(posedge i_ref_clk);
    f_multi <= 1'b0;
    start(8'h33, 8'h08);
    repeat (60) @(posedge i_ref_clk);
    chk("no restart", {7'h00, sys_rst}, 8'h01);
    chk("burn busy", {7'h00, busy_seen}, 8'h01);
    hrd(HREG_CTRL);
    chk("host held", rv, 8'h01);
    end_sim();
  end
endmodule
`default_nettype wire
